//--- core/ppi_pkg.sv
// Purpose: shared constants and carriers for the parallel port block
// Assumes: 8-bit host bus, 2-bit port select, three 8-bit ports
// Notes: control word and bit set/reset layouts kept here

package ppi_pkg;

   // port select codes
   localparam logic [1:0] PPI_SEL_A  = 2'h0;
   localparam logic [1:0] PPI_SEL_B  = 2'h1;
   localparam logic [1:0] PPI_SEL_C  = 2'h2;
   localparam logic [1:0] PPI_SEL_CW = 2'h3;

   // values after reset
   localparam logic [7:0] PPI_CW_RESET  = 8'h9B;
   localparam logic [7:0] PPI_OUT_RESET = 8'h00;

   // control word fields
   localparam int PPI_CW_MODE_SET = 7;
   localparam int PPI_CW_A_IN     = 4;
   localparam int PPI_CW_CU_IN    = 3;
   localparam int PPI_CW_B_IN     = 1;
   localparam int PPI_CW_CL_IN    = 0;

   // bit set/reset fields
   localparam int PPI_BSR_SEL_LSB = 1;
   localparam int PPI_BSR_SEL_MSB = 3;
   localparam int PPI_BSR_VALUE   = 0;

   // synchroniser depth in cycles
   localparam int PPI_SYNC_CYCLES = 2;

   // host bus pins sampled together
   typedef struct packed {
      logic       selN;
      logic       rdN;
      logic       wrN;
      logic [1:0] addr;
      logic [7:0] data;
   } ppi_host_s;

endpackage : ppi_pkg

//--- core/ppi_port.sv
// Purpose: host bus side of a 24-line programmable parallel port
// Assumes: host and port pins asynchronous to clock, synchronised by two flops
// Notes: basic input/output behaviour; pin hold is modelled outside
//
// Contract
// - 24 port lines in two groups of twelve, three modes
// - 8-bit three-state host data bus carries data, control, status
// - select low reaches the device; select high ignores the bus
// - selected read strobe low drives addressed data onto the bus
// - selected write strobe loads bus value into port or control
// - read decode: 0 port A, 1 port B, 2 port C, 3 control
// - write decode: 0 port A, 1 port B, 2 port C, 3 control
// - bus released when deselected or both strobes high
// - reset loads control 9B and makes every port an input
// - input-configured lines held at one by hold devices
// - group A owns port A and port C bits seven to four
// - group B owns port B and port C bits three to zero
// - control word readable, bit seven always reads one
// - port A has output latch and separate input path
// - port B has output latch and separate input buffer
// - port C latches output; input reads return live pins
// - port C splits into two halves, each with own latch
// - control word write with bit seven set zeroes every port latch, input or output
// - mode change clears all output registers
// - any single port C bit set or cleared in one write

`timescale 1ns/1ps

module ppi_port (
   input  wire logic       clock,
   input  wire logic       rst,
   input  wire logic       deviceSelectN,
   input  wire logic       readStrobeN,
   input  wire logic       writeStrobeN,
   input  wire logic       portSelectHi,
   input  wire logic       portSelectLo,
   input  wire logic [7:0] hostDataBusIn,
   output logic      [7:0] hostDataBusOut,
   output logic      [7:0] hostDataBusOeN,
   input  wire logic [7:0] portALinesIn,
   output logic      [7:0] portALinesOut,
   output logic      [7:0] portALinesOeN,
   input  wire logic [7:0] portBLinesIn,
   output logic      [7:0] portBLinesOut,
   output logic      [7:0] portBLinesOeN,
   input  wire logic [7:0] portCLinesIn,
   output logic      [7:0] portCLinesOut,
   output logic      [7:0] portCLinesOeN,
   output ppi_pkg::ppi_host_s hostSeen
);
   import ppi_pkg::*;

   ppi_host_s  hostRaw;
   ppi_host_s  hostMeta;
   ppi_host_s  hostSync;
   logic [23:0] pinMeta;
   logic [23:0] pinSync;
   logic [7:0] controlWord;
   logic [7:0] outA;
   logic [7:0] outB;
   logic [7:0] outC;
   logic       wrLow;
   logic [1:0] wrAddr;
   logic [7:0] wrData;

   // host pins gathered into one carrier
   assign hostRaw = '{selN: deviceSelectN, rdN: readStrobeN,
                      wrN: writeStrobeN,
                      addr: {portSelectHi, portSelectLo},
                      data: hostDataBusIn};

   // two-flop synchronisers for host and port pins
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hostMeta <= '1;
         hostSync <= '1;
         pinMeta  <= '1;
         pinSync  <= '1;
      end else begin
         hostMeta <= hostRaw;
         hostSync <= hostMeta;
         pinMeta  <= {portALinesIn, portBLinesIn, portCLinesIn};
         pinSync  <= pinMeta;
      end
   end

   // decoded strobes on synchronised pins
   wire        selected = ~hostSync.selN;
   wire        rdActive = selected & ~hostSync.rdN & hostSync.wrN;
   wire        wrActive = selected & ~hostSync.wrN & hostSync.rdN;
   wire        commit   = wrLow & hostSync.wrN;
   wire [7:0]  pinA     = pinSync[23:16];
   wire [7:0]  pinB     = pinSync[15:8];
   wire [7:0]  pinC     = pinSync[7:0];

   // direction bits per group, one means input
   wire        aIn  = controlWord[PPI_CW_A_IN];
   wire        cuIn = controlWord[PPI_CW_CU_IN];
   wire        bIn  = controlWord[PPI_CW_B_IN];
   wire        clIn = controlWord[PPI_CW_CL_IN];

   // write target decode
   wire        wrCw     = commit & (wrAddr == PPI_SEL_CW);
   wire        modeSet  = wrCw & wrData[PPI_CW_MODE_SET];
   wire        bitOp    = wrCw & ~wrData[PPI_CW_MODE_SET];
   wire [2:0]  bitIdx   = wrData[PPI_BSR_SEL_MSB:PPI_BSR_SEL_LSB];

   // read data per port: latch for outputs, live pins for inputs
   wire [7:0]  readA = aIn ? pinA : outA;
   wire [7:0]  readB = bIn ? pinB : outB;
   wire [7:0]  readC = {cuIn ? pinC[7:4] : outC[7:4],
                        clIn ? pinC[3:0] : outC[3:0]};
   wire [7:0]  readCw = {1'b1, controlWord[6:0]};
   wire [7:0]  readMux = (hostSync.addr == PPI_SEL_A) ? readA :
                         (hostSync.addr == PPI_SEL_B) ? readB :
                         (hostSync.addr == PPI_SEL_C) ? readC :
                         readCw;

   // write strobe capture, commit at end of low period
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         wrLow  <= 1'b0;
         wrAddr <= PPI_SEL_A;
         wrData <= PPI_OUT_RESET;
      end else if (wrActive) begin
         wrLow  <= 1'b1;
         wrAddr <= hostSync.addr;
         wrData <= hostSync.data;
      end else if (commit) begin
         wrLow  <= 1'b0;
      end
   end

   // control word and output latches
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         controlWord <= PPI_CW_RESET;
         outA        <= PPI_OUT_RESET;
         outB        <= PPI_OUT_RESET;
         outC        <= PPI_OUT_RESET;
      end else if (modeSet) begin
         controlWord <= wrData;
         outA        <= PPI_OUT_RESET;
         outB        <= PPI_OUT_RESET;
         outC        <= PPI_OUT_RESET;
      end else if (bitOp) begin
         outC[bitIdx] <= wrData[PPI_BSR_VALUE];
      end else if (commit) begin
         if (wrAddr == PPI_SEL_A) outA <= wrData;
         if (wrAddr == PPI_SEL_B) outB <= wrData;
         if (wrAddr == PPI_SEL_C) outC <= wrData;
      end
   end

   // host bus driver, released unless a clean read is seen
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hostDataBusOut <= PPI_OUT_RESET;
         hostDataBusOeN <= '1;
      end else begin
         hostDataBusOut <= readMux;
         hostDataBusOeN <= {8{~rdActive}};
      end
   end

   // port line drivers; released lines are held high outside
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         portALinesOut <= PPI_OUT_RESET;
         portBLinesOut <= PPI_OUT_RESET;
         portCLinesOut <= PPI_OUT_RESET;
         portALinesOeN <= '1;
         portBLinesOeN <= '1;
         portCLinesOeN <= '1;
      end else begin
         portALinesOut <= outA;
         portBLinesOut <= outB;
         portCLinesOut <= outC;
         portALinesOeN <= {8{aIn}};
         portBLinesOeN <= {8{bIn}};
         portCLinesOeN <= {{4{cuIn}}, {4{clIn}}};
      end
   end

   // synchronised host view for observation
   assign hostSeen = hostSync;

   // checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence wrEnd;
      wrActive ##1 (selected & hostSync.wrN);
   endsequence

   // mode write that makes port A an output, then its enable update
   sequence modeAOut;
      modeSet & !wrData[PPI_CW_A_IN] ##1 1'b1;
   endsequence

   // mode write that makes port B an input, then its enable update
   sequence modeBIn;
      modeSet & wrData[PPI_CW_B_IN] ##1 1'b1;
   endsequence

   a_write_ends_commit: assert property (wrEnd |-> commit)
      else $error("write end did not commit");

   a_write_once: assert property (commit |=> !commit)
      else $error("write committed twice");

   a_desel_release: assert property (hostSync.selN |=> &hostDataBusOeN)
      else $error("bus driven while deselected");

   a_idle_release: assert property
      (selected & hostSync.rdN & hostSync.wrN |=> &hostDataBusOeN)
      else $error("bus driven with both strobes high");

   a_read_drives_bus: assert property (rdActive |=> ~|hostDataBusOeN)
      else $error("read did not drive bus");

   a_cw_read_top: assert property
      (rdActive & (hostSync.addr == PPI_SEL_CW) |=> hostDataBusOut[7])
      else $error("control read bit seven low");

   a_read_port_a: assert property
      (rdActive & (hostSync.addr == PPI_SEL_A) & !aIn
       |=> hostDataBusOut == $past(outA))
      else $error("port A read wrong");

   a_write_port_b: assert property
      (commit & (wrAddr == PPI_SEL_B) |=> outB == $past(wrData))
      else $error("port B write lost");

   a_mode_clears: assert property
      (modeSet |=> (outA == 8'h00) && (outB == 8'h00) && (outC == 8'h00))
      else $error("mode write did not clear outputs");

   a_bit_op_c: assert property
      (bitOp |=> outC[$past(bitIdx)] == $past(wrData[PPI_BSR_VALUE]))
      else $error("port C bit operation wrong");

   a_bit_op_keep_cw: assert property
      (bitOp |=> $stable(controlWord))
      else $error("bit operation altered control word");

   a_group_a_dir: assert property
      (!cuIn & !aIn |=> (portCLinesOeN[7:4] == 4'h0) && (portALinesOeN == 8'h00))
      else $error("group A not driving");

   a_group_b_dir: assert property
      (clIn & bIn |=> (portCLinesOeN[3:0] == 4'hF) && (portBLinesOeN == 8'hFF))
      else $error("group B not released");

   // write path: data, control word and pin latches
   a_write_port_a: assert property
      (commit & (wrAddr == PPI_SEL_A) |=> outA == $past(wrData))
      else $error("port A write lost");

   a_write_port_c: assert property
      (commit & (wrAddr == PPI_SEL_C) |=> outC == $past(wrData))
      else $error("port C write lost");

   a_cw_load: assert property (modeSet |=> controlWord == $past(wrData))
      else $error("control word not loaded");

   a_desel_no_capture: assert property
      (hostSync.selN & !wrLow |=> !wrLow)
      else $error("write captured while deselected");

   a_bit_keep_ab: assert property
      (bitOp |=> $stable(outA) && $stable(outB))
      else $error("bit operation altered port A or B");

   a_pin_a_follow: assert property (portALinesOut == $past(outA))
      else $error("port A pins do not follow latch");

   a_pin_b_follow: assert property (portBLinesOut == $past(outB))
      else $error("port B pins do not follow latch");

   a_pin_c_follow: assert property (portCLinesOut == $past(outC))
      else $error("port C pins do not follow latch");

   // read path: input ports return synchronised pin levels, port C lower half set as output returns its latch
   a_read_a_pins: assert property
      (rdActive & (hostSync.addr == PPI_SEL_A) & aIn |=> hostDataBusOut == $past(pinA))
      else $error("port A input read wrong");

   a_read_b_pins: assert property
      (rdActive & (hostSync.addr == PPI_SEL_B) & bIn |=> hostDataBusOut == $past(pinB))
      else $error("port B input read wrong");

   a_read_c_upper: assert property
      (rdActive & (hostSync.addr == PPI_SEL_C) & cuIn
       |=> hostDataBusOut[7:4] == $past(pinC[7:4]))
      else $error("port C upper input read wrong");

   a_read_c_latch: assert property
      (rdActive & (hostSync.addr == PPI_SEL_C) & !clIn
       |=> hostDataBusOut[3:0] == $past(outC[3:0]))
      else $error("port C lower latch read wrong");

   // mode writes set the group directions
   a_mode_dir_a: assert property (modeAOut |=> portALinesOeN == 8'h00)
      else $error("port A not driven after mode write");

   a_mode_dir_b: assert property (modeBIn |=> portBLinesOeN == 8'hFF)
      else $error("port B not released after mode write");

endmodule : ppi_port

//--- verification/ppi_pin_model.sv
// Purpose: line level of one 8-bit port as the peripheral side sees it
// Assumes: device drives where its enable is low, peripheral may drive
// Notes: undriven released lines rest at one through hold devices
`timescale 1ns/1ps

module ppi_pin_model (
   input  wire logic [7:0] devOut,
   input  wire logic [7:0] devOeN,
   input  wire logic [7:0] extVal,
   input  wire logic [7:0] extEn,
   output logic      [7:0] level
);
   // per-bit resolution, hold keeps floating inputs high
   assign level = (~devOeN & devOut) | (devOeN & extEn & extVal)
                | (devOeN & ~extEn);
endmodule : ppi_pin_model

//--- verification/tb_ppi_port.sv
// Purpose: self-checking bench for the parallel port host side
// Assumes: host writes hold the strobe four cycles, reads three, gaps of three or more
// Notes: inputs change on the falling edge only
`timescale 1ns/1ps
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errCount++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module tb_ppi_port;
   import ppi_pkg::*;
   logic       clock, rst, selN, rdN, wrN, aHi, aLo, hostDrive, extOn;
   logic [7:0] hostData, busIn, busOut, busOeN, rdVal, bExt, cExt;
   logic [7:0] aOut, aOeN, bOut, bOeN, cOut, cOeN, aLvl, bLvl, cLvl;
   ppi_host_s  seen;
   int         errCount, nTests, i;

   // host data bus: host value, device value, or a changing float
   assign busIn = hostDrive ? hostData : ((busOeN == 8'h00) ? busOut : ~busOut);

   ppi_port dut (.clock(clock), .rst(rst), .deviceSelectN(selN), .readStrobeN(rdN),
      .writeStrobeN(wrN), .portSelectHi(aHi), .portSelectLo(aLo), .hostDataBusIn(busIn),
      .hostDataBusOut(busOut), .hostDataBusOeN(busOeN), .portALinesIn(aLvl),
      .portALinesOut(aOut), .portALinesOeN(aOeN), .portBLinesIn(bLvl),
      .portBLinesOut(bOut), .portBLinesOeN(bOeN), .portCLinesIn(cLvl),
      .portCLinesOut(cOut), .portCLinesOeN(cOeN), .hostSeen(seen));
   ppi_pin_model pinA (.devOut(aOut), .devOeN(aOeN), .extVal(8'h00), .extEn(8'h00),
      .level(aLvl));
   ppi_pin_model pinB (.devOut(bOut), .devOeN(bOeN), .extVal(bExt), .extEn({8{extOn}}),
      .level(bLvl));
   ppi_pin_model pinC (.devOut(cOut), .devOeN(cOeN), .extVal(cExt), .extEn({8{extOn}}),
      .level(cLvl));

   // verdict and end of run
   task automatic endOfTest();
      $display("comparisons %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : endOfTest

   // bounded wait for the bus enable to reach a level
   task automatic waitOe(input logic [7:0] want);
      int n;
      n = 0;
      while (busOeN !== want && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (busOeN !== want) begin
         errCount++;
         endOfTest();
      end
   endtask : waitOe

   // selected read, compared against the expected value
   task automatic chkRd(input logic [1:0] addr, input logic [7:0] exp);
      @(negedge clock);
      {aHi, aLo} = addr;
      selN = 1'b0;
      rdN = 1'b0;
      waitOe(8'h00);
      @(negedge clock);
      rdVal = busOut;
      rdN = 1'b1;
      selN = 1'b1;
      waitOe(8'hFF);
      `CHK(rdVal, exp)
      repeat (3) @(negedge clock);
   endtask : chkRd

   // write cycle, select level given so deselected writes can be tried
   task automatic hostWrite(input logic [1:0] addr, input logic [7:0] data, input logic s);
      @(negedge clock);
      {aHi, aLo} = addr;
      hostData = data;
      hostDrive = 1'b1;
      selN = s;
      wrN = 1'b0;
      repeat (4) @(negedge clock);
      wrN = 1'b1;
      selN = 1'b1;
      repeat (6) @(negedge clock);
      hostDrive = 1'b0;
   endtask : hostWrite

   // free-running clock
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   // main sequence
   initial begin
      rst = 1'b1;
      {selN, rdN, wrN, aHi, aLo, hostDrive, extOn} = 7'b1110000;
      {hostData, bExt, cExt} = 24'h0;
      errCount = 0;
      nTests = 0;
      repeat (4) @(negedge clock);
      rst = 1'b0;
      `CHK(aOeN & bOeN & cOeN, 8'hFF)
      chkRd(PPI_SEL_CW, PPI_CW_RESET);
      chkRd(PPI_SEL_A, 8'hFF);
      rdN = 1'b0;
      repeat (6) @(negedge clock);
      `CHK(busOeN, 8'hFF)
      rdN = 1'b1;
      hostWrite(PPI_SEL_CW, 8'h80, 1'b1);
      chkRd(PPI_SEL_CW, PPI_CW_RESET);
      hostWrite(PPI_SEL_CW, 8'h80, 1'b0);
      `CHK({aOeN, bOeN, cOeN, aOut}, 32'h0)
      hostWrite(PPI_SEL_A, 8'h5A, 1'b0);
      hostWrite(PPI_SEL_B, 8'hC3, 1'b0);
      hostWrite(PPI_SEL_C, 8'h96, 1'b0);
      `CHK({aOut, bOut, cOut}, 24'h5AC396)
      chkRd(PPI_SEL_A, 8'h5A);
      chkRd(PPI_SEL_B, 8'hC3);
      chkRd(PPI_SEL_C, 8'h96);
      // set then clear each port C bit in turn
      for (i = 0; i < 8; i++) begin
         hostWrite(PPI_SEL_CW, 8'(i * 2 + 1), 1'b0);
         `CHK(cOut[i], 1'b1)
         hostWrite(PPI_SEL_CW, 8'(i * 2), 1'b0);
         `CHK(cOut[i], 1'b0)
      end
      chkRd(PPI_SEL_CW, 8'h80);
      // mixed directions: latches cleared, inputs read live pins
      {bExt, cExt, extOn} = {8'h3C, 8'hA5, 1'b1};
      hostWrite(PPI_SEL_CW, 8'h8A, 1'b0);
      `CHK({aOeN, bOeN, cOeN}, 24'h00FFF0)
      `CHK({aOut, bOut, cOut}, 24'h000000)
      chkRd(PPI_SEL_B, 8'h3C);
      chkRd(PPI_SEL_C, 8'hA0);
      cExt = 8'h55;
      chkRd(PPI_SEL_C, 8'h50);
      hostWrite(PPI_SEL_C, 8'hFF, 1'b0);
      `CHK({cOut[3:0], cOeN}, 12'hFF0)
      `CHK({seen.selN, seen.rdN, seen.wrN, seen.addr}, 5'h1E)
      chkRd(PPI_SEL_CW, 8'h8A);
      // reset in mid-run restores the reset word
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      `CHK({bOeN, bOut}, 16'hFF00)
      chkRd(PPI_SEL_CW, PPI_CW_RESET);
      endOfTest();
   end
endmodule : tb_ppi_port
